//--- rtl/ops_out_pin_mux.sv
`timescale 1ns/1ps
// Behaviour
// RL1: each pin owns its selector field choosing which peripheral drives it.
// RL2: map registers hold two 5-bit fields, one field per pin.
// RL3: selected peripheral output goes to pin; codes 13-17, 23-28 and 31 connect nothing.
// RL4: code zero is null; pin stays disconnected from every peripheral output.
// RL5: reset loads null into every selector, disabling remapped outputs.
// RL6: codes 3,5 are uart transmit; codes 4,6 are uart request-to-send.
// RL7: codes 7,8,9 are first spi data, clock, select outputs.
// RL8: codes 10,11,12 are second spi data, clock, select outputs.
// RL9: 18-22 compare units, 1,2,30 comparators, 29 time-measure pulse.
// RL10: in infrared mode the uart baud clock replaces request-to-send.
// RL11: output mapping is independent of any input mapping.
// RL12: null or unused code leaves pin to its general-purpose port logic.
module ops_out_pin_mux (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // map register write and read-back
    input wire logic mapWrite,
    input wire logic [ops_pkg::IDX_W-1:0] mapRegIndex,
    input wire logic [ops_pkg::REG_W-1:0] mapRegData,
    output logic [ops_pkg::REG_W-1:0] mapRegRead,
    // comparators
    input wire logic comparator_one_out,
    input wire logic comparator_two_out,
    input wire logic comparator_three_out,
    // uarts
    input wire logic uart_a_transmit,
    input wire logic uart_a_request_send,
    input wire logic uartAInfrared,
    input wire logic uartABaudClock,
    input wire logic uart_b_transmit,
    input wire logic uart_b_request_send,
    input wire logic uartBInfrared,
    input wire logic uartBBaudClock,
    // spi units
    input wire logic spi_a_data_out,
    input wire logic spi_a_clock_out,
    input wire logic spi_a_select_out,
    input wire logic spi_b_data_out,
    input wire logic spi_b_clock_out,
    input wire logic spi_b_select_out,
    // output compare units and time pulse
    input wire logic compare_unit_one_out,
    input wire logic compare_unit_two_out,
    input wire logic compare_unit_three_out,
    input wire logic compare_unit_four_out,
    input wire logic compare_unit_five_out,
    input wire logic time_measure_pulse,
    // general-purpose port logic per pin
    input wire logic [ops_pkg::NUM_PINS-1:0] gpioOut,
    input wire logic [ops_pkg::NUM_PINS-1:0] gpioOe_n,
    // remappable pins
    output logic [ops_pkg::NUM_PINS-1:0] remappable_pin,
    output logic [ops_pkg::NUM_PINS-1:0] remappable_pinOe_n
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ops_pkg::ops_state_t st;
    ops_pkg::ops_state_t next_st;
    logic [31:0] srcVec;
    logic [ops_pkg::NUM_PINS-1:0] pinRouted;
    logic [ops_pkg::NUM_PINS-1:0] pinConnected;

    // ----------------------------------------------------------------
    // source vector, indexed by selector code
    // ----------------------------------------------------------------
    always_comb begin
        srcVec = 32'h0000_0000; // RL3
        srcVec[ops_pkg::CODE_CMP_ONE] = comparator_one_out; // RL9
        srcVec[ops_pkg::CODE_CMP_TWO] = comparator_two_out; // RL9
        srcVec[ops_pkg::CODE_CMP_THREE] = comparator_three_out; // RL9
        srcVec[ops_pkg::CODE_UART_A_TX] = uart_a_transmit; // RL6
        srcVec[ops_pkg::CODE_UART_B_TX] = uart_b_transmit; // RL6
        // infrared encoder borrows the request-to-send slot for its baud clock
        srcVec[ops_pkg::CODE_UART_A_RTS] = uartAInfrared ? uartABaudClock
                                                         : uart_a_request_send; // RL6 RL10
        srcVec[ops_pkg::CODE_UART_B_RTS] = uartBInfrared ? uartBBaudClock
                                                         : uart_b_request_send; // RL6 RL10
        srcVec[ops_pkg::CODE_SPI_A_DATA] = spi_a_data_out; // RL7
        srcVec[ops_pkg::CODE_SPI_A_CLK] = spi_a_clock_out; // RL7
        srcVec[ops_pkg::CODE_SPI_A_SEL] = spi_a_select_out; // RL7
        srcVec[ops_pkg::CODE_SPI_B_DATA] = spi_b_data_out; // RL8
        srcVec[ops_pkg::CODE_SPI_B_CLK] = spi_b_clock_out; // RL8
        srcVec[ops_pkg::CODE_SPI_B_SEL] = spi_b_select_out; // RL8
        srcVec[ops_pkg::CODE_CMPU_ONE] = compare_unit_one_out; // RL9
        srcVec[ops_pkg::CODE_CMPU_TWO] = compare_unit_two_out; // RL9
        srcVec[ops_pkg::CODE_CMPU_THREE] = compare_unit_three_out; // RL9
        srcVec[ops_pkg::CODE_CMPU_FOUR] = compare_unit_four_out; // RL9
        srcVec[ops_pkg::CODE_CMPU_FIVE] = compare_unit_five_out; // RL9
        srcVec[ops_pkg::CODE_TIME_PULSE] = time_measure_pulse; // RL9
    end

    // ----------------------------------------------------------------
    // one selector per pin
    // ----------------------------------------------------------------
    generate
        for (genvar p = 0; p < ops_pkg::NUM_PINS; p++) begin : g_pin
            ops_source_sel u_sel (
                .code(st.sel[p]), // RL1
                .sources(srcVec),
                .routed(pinRouted[p]),
                .connected(pinConnected[p])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [4:0] loPin;
        logic [4:0] hiPin;
        logic idxOk;
        loPin = {mapRegIndex, 1'b0};
        hiPin = {mapRegIndex, 1'b1};
        idxOk = (mapRegIndex < ops_pkg::IDX_W'(ops_pkg::NUM_REGS));
        next_st = st;
        // writes touch only the output map; nothing here looks at input routing
        if (mapWrite && idxOk) begin // RL11
            next_st.sel[loPin] = mapRegData[ops_pkg::LO_FIELD_POS +: ops_pkg::FIELD_W]; // RL2
            next_st.sel[hiPin] = mapRegData[ops_pkg::HI_FIELD_POS +: ops_pkg::FIELD_W]; // RL2
        end
        // read-back shows the stored fields, other bits read zero
        next_st.readData = ops_pkg::READ_RESET;
        if (idxOk) begin
            next_st.readData[ops_pkg::LO_FIELD_POS +: ops_pkg::FIELD_W] = st.sel[loPin]; // RL2
            next_st.readData[ops_pkg::HI_FIELD_POS +: ops_pkg::FIELD_W] = st.sel[hiPin]; // RL2
        end
        for (int p = 0; p < ops_pkg::NUM_PINS; p++) begin
            if (pinConnected[p]) begin
                next_st.pinOut[p] = pinRouted[p]; // RL3
                next_st.pinOe_n[p] = 1'b0; // RL3
            end else begin
                next_st.pinOut[p] = gpioOut[p]; // RL12 RL4
                next_st.pinOe_n[p] = gpioOe_n[p]; // RL12 RL4
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st.sel <= {ops_pkg::NUM_PINS{ops_pkg::SEL_RESET}}; // RL5
            st.pinOut <= {ops_pkg::NUM_PINS{ops_pkg::PIN_OUT_RESET}};
            st.pinOe_n <= {ops_pkg::NUM_PINS{ops_pkg::PIN_OE_N_RESET}};
            st.readData <= ops_pkg::READ_RESET;
        end else begin
            st <= next_st;
        end
    end

    // one cycle of latency on every pin, traded for flop-driven outputs
    assign remappable_pin = st.pinOut;
    assign remappable_pinOe_n = st.pinOe_n;
    assign mapRegRead = st.readData;

endmodule

//--- rtl/ops_pkg.sv
package ops_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int FIELD_W = 5;
    localparam int NUM_REGS = 13;
    localparam int NUM_PINS = 2 * NUM_REGS;
    localparam int REG_W = 16;
    localparam int IDX_W = 4;
    localparam int LO_FIELD_POS = 0;
    localparam int HI_FIELD_POS = 8;

    // ----------------------------------------------------------------
    // selector codes
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        CODE_NULL = 5'h00,
        CODE_CMP_ONE = 5'h01,
        CODE_CMP_TWO = 5'h02,
        CODE_UART_A_TX = 5'h03,
        CODE_UART_A_RTS = 5'h04,
        CODE_UART_B_TX = 5'h05,
        CODE_UART_B_RTS = 5'h06,
        CODE_SPI_A_DATA = 5'h07,
        CODE_SPI_A_CLK = 5'h08,
        CODE_SPI_A_SEL = 5'h09,
        CODE_SPI_B_DATA = 5'h0A,
        CODE_SPI_B_CLK = 5'h0B,
        CODE_SPI_B_SEL = 5'h0C,
        CODE_CMPU_ONE = 5'h12,
        CODE_CMPU_TWO = 5'h13,
        CODE_CMPU_THREE = 5'h14,
        CODE_CMPU_FOUR = 5'h15,
        CODE_CMPU_FIVE = 5'h16,
        CODE_TIME_PULSE = 5'h1D,
        CODE_CMP_THREE = 5'h1E
    } ops_code_t;

    // one bit per code that reaches a peripheral; 0, 13-17, 23-28, 31 clear
    localparam logic [31:0] CODE_USED_MASK = 32'h607C_1FFE;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [FIELD_W-1:0] SEL_RESET = CODE_NULL;
    localparam logic PIN_OUT_RESET = 1'b0;
    localparam logic PIN_OE_N_RESET = 1'b1;
    localparam logic [REG_W-1:0] READ_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PINS-1:0][FIELD_W-1:0] sel;
        logic [NUM_PINS-1:0] pinOut;
        logic [NUM_PINS-1:0] pinOe_n;
        logic [REG_W-1:0] readData;
    } ops_state_t;

    function automatic logic code_connects(input logic [FIELD_W-1:0] code);
        code_connects = CODE_USED_MASK[code];
    endfunction

endpackage

//--- rtl/ops_source_sel.sv
`timescale 1ns/1ps
module ops_source_sel (
    // selector field of one pin
    input wire logic [4:0] code,
    // all peripheral outputs, indexed by code
    input wire logic [31:0] sources,
    // result
    output logic routed,
    output logic connected
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign connected = ops_pkg::code_connects(code); // RL3 RL4
    assign routed = connected ? sources[code] : 1'b0; // RL3

endmodule

//--- dv/ops_out_pin_mux_assertions.sv
`timescale 1ns/1ps
module ops_out_pin_mux_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // map register access
    input wire logic mapWrite,
    input wire logic [ops_pkg::IDX_W-1:0] mapRegIndex,
    input wire logic [ops_pkg::REG_W-1:0] mapRegData,
    input wire logic [ops_pkg::REG_W-1:0] mapRegRead,
    // sources watched
    input wire logic uart_a_request_send,
    input wire logic uartAInfrared,
    input wire logic uartABaudClock,
    input wire logic spi_a_data_out,
    // port logic and pins
    input wire logic [ops_pkg::NUM_PINS-1:0] gpioOut,
    input wire logic [ops_pkg::NUM_PINS-1:0] gpioOe_n,
    input wire logic [ops_pkg::NUM_PINS-1:0] remappable_pin,
    input wire logic [ops_pkg::NUM_PINS-1:0] remappable_pinOe_n
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_write_readback: assert property (mapWrite && mapRegIndex < 4'hD ##1 !mapWrite
        && $stable(mapRegIndex) |=> mapRegRead == {3'h0, $past(mapRegData[12:8], 2),
        3'h0, $past(mapRegData[4:0], 2)}) else $error("read-back differs from write");
    a_bad_index: assert property (mapRegIndex > 4'hC |=> mapRegRead == 16'h0000)
        else $error("unmapped index reads nonzero");
    a_spare_bits: assert property (mapRegRead[15:13] == 3'h0 && mapRegRead[7:5] == 3'h0)
        else $error("spare read bits set");
    a_oe_follow: assert property ($past(arst_n) |->
        (remappable_pinOe_n & ~$past(gpioOe_n)) == '0) else $error("released pin enable wrong");
    a_data_follow: assert property ($past(arst_n) |->
        ((remappable_pin ^ $past(gpioOut)) & remappable_pinOe_n) == '0)
        else $error("released pin data wrong");
    a_reset_null: assert property ($rose(arst_n) |=> remappable_pin == $past(gpioOut)
        && remappable_pinOe_n == $past(gpioOe_n) && mapRegRead == 16'h0000)
        else $error("selectors not null after reset");
    a_spi_route: assert property ($past(mapRegIndex) == 4'h0
        && mapRegRead[4:0] == ops_pkg::CODE_SPI_A_DATA |-> !remappable_pinOe_n[0]
        && remappable_pin[0] == $past(spi_a_data_out)) else $error("spi data not routed");
    a_rts_baud: assert property ($past(mapRegIndex) == 4'h0
        && mapRegRead[12:8] == ops_pkg::CODE_UART_A_RTS |-> !remappable_pinOe_n[1]
        && remappable_pin[1] == ($past(uartAInfrared) ? $past(uartABaudClock)
        : $past(uart_a_request_send))) else $error("rts or baud clock not routed");
endmodule
bind ops_out_pin_mux ops_out_pin_mux_assertions u_chk (.clk(clk), .arst_n(arst_n),
    .mapWrite(mapWrite), .mapRegIndex(mapRegIndex), .mapRegData(mapRegData),
    .mapRegRead(mapRegRead), .uart_a_request_send(uart_a_request_send),
    .uartAInfrared(uartAInfrared), .uartABaudClock(uartABaudClock),
    .spi_a_data_out(spi_a_data_out), .gpioOut(gpioOut), .gpioOe_n(gpioOe_n),
    .remappable_pin(remappable_pin), .remappable_pinOe_n(remappable_pinOe_n));

//--- dv/ops_periph_model.sv
`timescale 1ns/1ps
module ops_periph_model (
    // which peripheral output is high
    input wire logic hotEn,
    input wire logic [4:0] hot,
    // peripheral outputs indexed by selector code
    output logic [31:0] src
);
    // one source high at a time, so a wrong pick shows as a low pin
    assign src = hotEn ? (32'h0000_0001 << hot) : 32'h0000_0000;
endmodule

//--- dv/output_pin_select_mux_test.sv
`timescale 1ns/1ps
module output_pin_select_mux_test;
    logic clk, arst_n, mapWrite, aIr, aBaud, bIr, bBaud, hotEn;
    logic [3:0] mapRegIndex;
    logic [15:0] mapRegData, mapRegRead;
    logic [4:0] hot;
    logic [31:0] src;
    logic [25:0] gpioOut, gpioOe_n, pin, pinOe_n;
    int err_total, num_checks;
    // ----------------------------------------------------------------
    // harness
    // ----------------------------------------------------------------
    ops_periph_model u_model (.hotEn(hotEn), .hot(hot), .src(src));
    ops_out_pin_mux u_dut (.clk(clk), .arst_n(arst_n), .mapWrite(mapWrite),
        .mapRegIndex(mapRegIndex), .mapRegData(mapRegData), .mapRegRead(mapRegRead),
        .comparator_one_out(src[1]), .comparator_two_out(src[2]),
        .comparator_three_out(src[30]), .uart_a_transmit(src[3]),
        .uart_a_request_send(src[4]), .uartAInfrared(aIr), .uartABaudClock(aBaud),
        .uart_b_transmit(src[5]), .uart_b_request_send(src[6]), .uartBInfrared(bIr),
        .uartBBaudClock(bBaud), .spi_a_data_out(src[7]), .spi_a_clock_out(src[8]),
        .spi_a_select_out(src[9]), .spi_b_data_out(src[10]), .spi_b_clock_out(src[11]),
        .spi_b_select_out(src[12]), .compare_unit_one_out(src[18]),
        .compare_unit_two_out(src[19]), .compare_unit_three_out(src[20]),
        .compare_unit_four_out(src[21]), .compare_unit_five_out(src[22]),
        .time_measure_pulse(src[29]), .gpioOut(gpioOut), .gpioOe_n(gpioOe_n),
        .remappable_pin(pin), .remappable_pinOe_n(pinOe_n));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic write_reg(input logic [3:0] idx, input logic [15:0] data);
        @(negedge clk);
        mapWrite = 1'b1;
        mapRegIndex = idx;
        mapRegData = data;
        @(negedge clk);
        mapWrite = 1'b0;
    endtask
    function automatic logic used(input int c);
        return (c >= 1 && c <= 12) || (c >= 18 && c <= 22) || c == 29 || c == 30;
    endfunction
    // held for ten cycles, then every register reads null and pins go to port logic
    task automatic test_reset;
        arst_n = 1'b0;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        for (int k = 0; k < 16; k++) begin
            mapRegIndex = k[3:0];
            @(negedge clk);
            check(mapRegRead, 32'h0000_0000);
        end
        check(pin, gpioOut);
        check(pinOe_n, gpioOe_n);
    endtask
    // every code on both fields of a register; source bit c alone is high
    task automatic test_codes;
        gpioOut = '0;
        gpioOe_n = '1;
        for (int c = 0; c < 32; c++) begin
            write_reg(4'((c + 6) % 13), {3'h0, 5'(c), 3'h0, 5'(c)});
            hot = 5'(c);
            @(negedge clk);
            check(mapRegRead, {3'h0, 5'(c), 3'h0, 5'(c)});
            check(pin[2*((c+6)%13) +: 2], {2{used(c)}});
            check(pinOe_n[2*((c+6)%13) +: 2], {2{~used(c)}});
            // all sources low: a routed pin must follow down, not stick high
            hotEn = 1'b0;
            @(negedge clk);
            check(pin[2*((c+6)%13) +: 2], 32'h0000_0000);
            hotEn = 1'b1;
        end
    endtask
    // infrared swaps request-to-send for the baud clock on both uarts
    task automatic test_infrared;
        write_reg(4'h0, 16'h0406);
        hot = 5'h04;
        for (int m = 0; m < 4; m++) begin
            aIr = m[1];
            bIr = m[1];
            aBaud = m[0];
            bBaud = m[0];
            @(negedge clk);
            check(pin[1:0], {m[1] ? m[0] : 1'b1, m[1] ? m[0] : 1'b0});
        end
    endtask
    // unmapped index: no effect, reads zero
    task automatic test_bad_index;
        write_reg(4'hD, 16'h1F1F);
        @(negedge clk);
        check(mapRegRead, 32'h0000_0000);
        mapRegIndex = 4'h0;
        @(negedge clk);
        check(mapRegRead, 32'h0000_0406);
    endtask
    task automatic results;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        {arst_n, mapWrite, aIr, aBaud, bIr, bBaud, hotEn} = 7'h01;
        {mapRegIndex, mapRegData, hot} = '0;
        gpioOut = 26'h2AA_AAAA;
        gpioOe_n = 26'h155_5555;
        test_reset;
        test_codes;
        test_infrared;
        test_bad_index;
        gpioOut = 26'h155_5555;
        test_reset;
        results;
    end
    // whole run is under two hundred cycles; this is generous
    initial begin
        #(8 * 4000);
        err_total++;
        results;
    end
endmodule
